/* design/ptc_addr_match.sv */
// module: destination address match against enabled timing addresses
`timescale 1ns/1ps
module ptc_addr_match (
	// enables and auxiliary address
	input  wire ptc_pkg::ptc_match_en_t en,
	input  wire logic [47:0]            aux_addr,
	// frame destination
	input  wire logic [47:0]            daddr,
	// result
	output logic                        hit
);
	import ptc_pkg::*;

	// ----------------------------------------------------------------
	// compare
	// ----------------------------------------------------------------
	always_comb begin
		hit = 1'b0;
		if (en.pri && daddr == ADDR_PRI) begin
			hit = 1'b1;
		end
		if (en.alt1 && daddr == ADDR_ALT1) begin
			hit = 1'b1;
		end
		if (en.alt2 && daddr == ADDR_ALT2) begin
			hit = 1'b1;
		end
		if (en.alt3 && daddr == ADDR_ALT3) begin
			hit = 1'b1;
		end
		if (en.aux && daddr == aux_addr) begin
			hit = 1'b1;
		end
	end

endmodule

/* design/ptc_pkg.sv */
// package: constants and types for the timestamp port configuration block
// Summary of operation
// - port 2 master: tx Sync, rx Delay_Req
// - port 2 slave (reset): tx Delay_Req, rx Sync
// - bit 30 enables address ...01:81, resets one
// - bit 29 enables address ...01:82, resets zero
// - bit 28 enables address ...01:83, resets zero
// - bit 27 enables address ...01:84, resets zero
// - bit 26 enables auxiliary address, resets zero
// - rx lock keeps capture while rx flag set
// - tx lock keeps capture while tx flag set
// - port 1 master: tx Sync, rx Delay_Req
// - port 1 slave (reset): tx Delay_Req, rx Sync
// - auxiliary address: 16-bit upper, 32-bit lower
package ptc_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int unsigned OFS_W         = 12;
	localparam logic [11:0] OFF_AUX_UPPER = 12'h18C;
	localparam logic [11:0] OFF_AUX_LOWER = 12'h190;
	localparam logic [11:0] OFF_CFG       = 12'h194;
	localparam logic [11:0] OFF_IRQ_STAT  = 12'h198;
	localparam logic [11:0] OFF_IRQ_MASK  = 12'h19C;

	// ----------------------------------------------------------------
	// configuration fields
	// ----------------------------------------------------------------
	localparam int unsigned CFG_P2_MASTER   = 31;
	localparam int unsigned CFG_P2_PRI_EN   = 30;
	localparam int unsigned CFG_P2_ALT1_EN  = 29;
	localparam int unsigned CFG_P2_ALT2_EN  = 28;
	localparam int unsigned CFG_P2_ALT3_EN  = 27;
	localparam int unsigned CFG_P2_AUX_EN   = 26;
	localparam int unsigned CFG_P2_LOCK_RX  = 25;
	localparam int unsigned CFG_P2_LOCK_TX  = 24;
	localparam int unsigned CFG_P1_MASTER   = 23;
	localparam logic [31:0] CFG_RST         = 32'h4300_0000;
	localparam logic [31:0] CFG_WMASK       = 32'hFF80_0000;
	localparam int unsigned AUX_UPPER_W     = 16;
	localparam logic [15:0] AUX_UPPER_RST   = 16'h0000;
	localparam logic [31:0] AUX_LOWER_RST   = 32'h0000_0000;

	// ----------------------------------------------------------------
	// fixed timing-packet addresses
	// ----------------------------------------------------------------
	localparam logic [47:0] ADDR_PRI  = 48'h0100_5E00_0181;
	localparam logic [47:0] ADDR_ALT1 = 48'h0100_5E00_0182;
	localparam logic [47:0] ADDR_ALT2 = 48'h0100_5E00_0183;
	localparam logic [47:0] ADDR_ALT3 = 48'h0100_5E00_0184;

	// ----------------------------------------------------------------
	// capture events and interrupts
	// ----------------------------------------------------------------
	localparam int unsigned NUM_EV    = 4;
	localparam int unsigned EV_P2_RX  = 0;
	localparam int unsigned EV_P2_TX  = 1;
	localparam int unsigned EV_P1_RX  = 2;
	localparam int unsigned EV_P1_TX  = 3;
	localparam logic [3:0]  STAT_RST  = 4'h0;
	localparam logic [3:0]  MASK_RST  = 4'h0;

	// ----------------------------------------------------------------
	// bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic        is_sync;
		logic        is_dreq;
		logic [47:0] daddr;
	} ptc_msg_t;

	typedef struct packed {
		logic pri;
		logic alt1;
		logic alt2;
		logic alt3;
		logic aux;
	} ptc_match_en_t;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_AUX_UPPER,
		SEL_AUX_LOWER,
		SEL_CFG,
		SEL_IRQ_STAT,
		SEL_IRQ_MASK
	} ptc_sel_t;

endpackage

/* design/ptc_port_config.sv */
// module: timestamp port configuration with AXI4-Lite registers
`timescale 1ns/1ps
module ptc_port_config #(
	parameter int unsigned ADDR_W = 12
) (
	// clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// write address channel
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	// write data channel
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	// write response channel
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// read address channel
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	// read data channel
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// frame path messages
	input  wire ptc_pkg::ptc_msg_t    p2_rx_msg,
	input  wire ptc_pkg::ptc_msg_t    p2_tx_msg,
	input  wire ptc_pkg::ptc_msg_t    p1_rx_msg,
	input  wire ptc_pkg::ptc_msg_t    p1_tx_msg,
	// capture side
	output logic [3:0]                cap_strobe,
	output logic [3:0]                irq_pending,
	output logic [47:0]               aux_addr,
	// interrupt
	output logic                      irq
);
	import ptc_pkg::*;

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (ADDR_W < OFS_W) begin : g_bad_addr_w
		$error("ADDR_W too small for the register map");
	end

	if (NUM_EV != 4) begin : g_bad_num_ev
		$error("event count must match the four capture strobes");
	end

	if (AUX_UPPER_W != 16) begin : g_bad_aux_w
		$error("auxiliary address must total 48 bits");
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic ptc_sel_t reg_sel(input logic [ADDR_W-1:0] a);
		logic [OFS_W-1:0] o;
		o = {a[OFS_W-1:2], 2'b00};
		unique case (o)
			OFF_AUX_UPPER: reg_sel = SEL_AUX_UPPER;
			OFF_AUX_LOWER: reg_sel = SEL_AUX_LOWER;
			OFF_CFG:       reg_sel = SEL_CFG;
			OFF_IRQ_STAT:  reg_sel = SEL_IRQ_STAT;
			OFF_IRQ_MASK:  reg_sel = SEL_IRQ_MASK;
			default:       reg_sel = SEL_NONE;
		endcase
	endfunction

	function automatic logic [31:0] wmerge(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		wmerge = r;
	endfunction

	// master: tx Sync, rx Delay_Req; slave: tx Delay_Req, rx Sync
	function automatic logic role_hit(
		input logic     master,
		input logic     is_tx,
		input ptc_msg_t m
	);
		logic want_sync;
		want_sync = master ? is_tx : !is_tx;
		role_hit  = m.valid && (want_sync ? m.is_sync : m.is_dreq);
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic                   aw_held_ff;
	logic [ADDR_W-1:0]      awaddr_ff;
	logic                   w_held_ff;
	logic [31:0]            wdata_ff;
	logic [3:0]             wstrb_ff;
	logic                   bvalid_ff;
	logic [1:0]             bresp_ff;
	logic                   rvalid_ff;
	logic [31:0]            rdata_ff;
	logic [1:0]             rresp_ff;
	logic [31:0]            cfg_ff;
	logic [15:0]            aux_upper_ff;
	logic [31:0]            aux_lower_ff;
	logic [3:0]             stat_ff;
	logic [3:0]             mask_ff;
	logic [3:0]             cap_ff;
	logic                   irq_ff;
	logic [3:0]             nxt_stat;
	logic [3:0]             cap_go;
	logic [3:0]             w1c;
	logic                   wr_fire;
	logic                   rd_fire;
	ptc_sel_t               wr_sel;
	ptc_sel_t               rd_sel;
	logic [31:0]            rd_word;
	logic [31:0]            wr_word;
	logic [31:0]            upper_word;
	logic [47:0]            aux_full;
	ptc_match_en_t          p2_en;
	logic                   p2_rx_addr_ok;
	logic                   p2_tx_addr_ok;

	// ----------------------------------------------------------------
	// bus handshakes
	// ----------------------------------------------------------------
	assign s_axi_awready = !aw_held_ff;
	assign s_axi_wready  = !w_held_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
	assign rd_fire = s_axi_arvalid && !rvalid_ff;
	assign wr_sel  = reg_sel(awaddr_ff);
	assign rd_sel  = reg_sel(s_axi_araddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			awaddr_ff  <= '0;
		end else if (s_axi_awvalid && !aw_held_ff) begin
			aw_held_ff <= 1'b1;
			awaddr_ff  <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_ff <= 1'b0;
			wdata_ff  <= '0;
			wstrb_ff  <= '0;
		end else if (s_axi_wvalid && !w_held_ff) begin
			w_held_ff <= 1'b1;
			wdata_ff  <= s_axi_wdata;
			wstrb_ff  <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always_comb begin
		rd_word = '0;
		unique case (rd_sel)
			SEL_AUX_UPPER: rd_word = {16'h0000, aux_upper_ff};
			SEL_AUX_LOWER: rd_word = aux_lower_ff;
			SEL_CFG:       rd_word = cfg_ff;
			SEL_IRQ_STAT:  rd_word = {28'h000_0000, stat_ff};
			SEL_IRQ_MASK:  rd_word = {28'h000_0000, mask_ff};
			SEL_NONE:      rd_word = '0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_word;
			rresp_ff  <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// configuration register
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_ff <= CFG_RST;
		end else if (wr_fire && wr_sel == SEL_CFG) begin
			cfg_ff <= wmerge(cfg_ff, wdata_ff, wstrb_ff) & CFG_WMASK;
		end
	end

	// ----------------------------------------------------------------
	// auxiliary address
	// ----------------------------------------------------------------
	assign wr_word    = wmerge(aux_lower_ff, wdata_ff, wstrb_ff);
	assign upper_word = wmerge({16'h0000, aux_upper_ff}, wdata_ff, wstrb_ff);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aux_upper_ff <= AUX_UPPER_RST;
		end else if (wr_fire && wr_sel == SEL_AUX_UPPER) begin
			aux_upper_ff <= upper_word[AUX_UPPER_W-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aux_lower_ff <= AUX_LOWER_RST;
		end else if (wr_fire && wr_sel == SEL_AUX_LOWER) begin
			aux_lower_ff <= wr_word;
		end
	end

	assign aux_full = {aux_upper_ff, aux_lower_ff};
	assign aux_addr = aux_full;

	// ----------------------------------------------------------------
	// port 2 address qualification
	// ----------------------------------------------------------------
	always_comb begin
		p2_en.pri  = cfg_ff[CFG_P2_PRI_EN];
		p2_en.alt1 = cfg_ff[CFG_P2_ALT1_EN];
		p2_en.alt2 = cfg_ff[CFG_P2_ALT2_EN];
		p2_en.alt3 = cfg_ff[CFG_P2_ALT3_EN];
		p2_en.aux  = cfg_ff[CFG_P2_AUX_EN];
	end

	ptc_addr_match u_p2_rx_match (
		.en       (p2_en),
		.aux_addr (aux_full),
		.daddr    (p2_rx_msg.daddr),
		.hit      (p2_rx_addr_ok)
	);

	ptc_addr_match u_p2_tx_match (
		.en       (p2_en),
		.aux_addr (aux_full),
		.daddr    (p2_tx_msg.daddr),
		.hit      (p2_tx_addr_ok)
	);

	// ----------------------------------------------------------------
	// capture decision
	// ----------------------------------------------------------------
	always_comb begin
		cap_go = '0;
		cap_go[EV_P2_RX] = role_hit(cfg_ff[CFG_P2_MASTER], 1'b0, p2_rx_msg)
			&& p2_rx_addr_ok
			&& !(cfg_ff[CFG_P2_LOCK_RX] && stat_ff[EV_P2_RX]);
		cap_go[EV_P2_TX] = role_hit(cfg_ff[CFG_P2_MASTER], 1'b1, p2_tx_msg)
			&& p2_tx_addr_ok
			&& !(cfg_ff[CFG_P2_LOCK_TX] && stat_ff[EV_P2_TX]);
		cap_go[EV_P1_RX] = role_hit(cfg_ff[CFG_P1_MASTER], 1'b0, p1_rx_msg);
		cap_go[EV_P1_TX] = role_hit(cfg_ff[CFG_P1_MASTER], 1'b1, p1_tx_msg);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_ff <= '0;
		end else begin
			cap_ff <= cap_go;
		end
	end

	assign cap_strobe = cap_ff;

	// ----------------------------------------------------------------
	// interrupt status and mask
	// ----------------------------------------------------------------
	always_comb begin
		w1c = '0;
		if (wr_fire && wr_sel == SEL_IRQ_STAT && wstrb_ff[0]) begin
			w1c = wdata_ff[3:0];
		end
		nxt_stat = (stat_ff & ~w1c) | cap_go;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_ff <= STAT_RST;
		end else begin
			stat_ff <= nxt_stat;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_ff <= MASK_RST;
		end else if (wr_fire && wr_sel == SEL_IRQ_MASK && wstrb_ff[0]) begin
			mask_ff <= wdata_ff[3:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(nxt_stat & mask_ff);
		end
	end

	assign irq_pending = stat_ff;
	assign irq         = irq_ff;

endmodule

/* dv/ptc_frame_src.sv */
// model: frame path offering timing messages to the four capture inputs
`timescale 1ns/1ps
module ptc_frame_src (
	// clock
	input  wire logic        aclk,
	// messages
	output ptc_pkg::ptc_msg_t p2_rx_msg,
	output ptc_pkg::ptc_msg_t p2_tx_msg,
	output ptc_pkg::ptc_msg_t p1_rx_msg,
	output ptc_pkg::ptc_msg_t p1_tx_msg
);
	import ptc_pkg::*;
	ptc_msg_t m_ff [4];
	assign p2_rx_msg = m_ff[0];
	assign p2_tx_msg = m_ff[1];
	assign p1_rx_msg = m_ff[2];
	assign p1_tx_msg = m_ff[3];
	initial begin
		for (int i = 0; i < 4; i++) m_ff[i] = '0;
	end
	// one-cycle message after an idle gap, then inverted leftovers
	task automatic send(input int p, input logic s, input logic d, input logic [47:0] a,
		input int gap);
		repeat (gap + 1) @(posedge aclk);
		m_ff[p] <= '{1'b1, s, d, a};
		@(posedge aclk);
		m_ff[p] <= '{1'b0, ~s, ~d, ~a};
	endtask
endmodule

/* dv/ptc_port_config_assertions.sv */
// checker: port-level properties of the timestamp port configuration block
`timescale 1ns/1ps
module ptc_port_config_chk (
	// clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// register bus
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [1:0]        s_axi_bresp,
	// frame path and capture
	input wire ptc_pkg::ptc_msg_t p2_rx_msg,
	input wire ptc_pkg::ptc_msg_t p2_tx_msg,
	input wire ptc_pkg::ptc_msg_t p1_rx_msg,
	input wire ptc_pkg::ptc_msg_t p1_tx_msg,
	input wire logic [3:0]        cap_strobe,
	input wire logic [3:0]        irq_pending,
	input wire logic [47:0]       aux_addr,
	input wire logic              irq
);
	import ptc_pkg::*;
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_p2rx_strobe_cause: assert property (cap_strobe[0] |-> $past(p2_rx_msg.valid))
		else $error("port 2 rx strobe without message");
	a_p2tx_strobe_cause: assert property (cap_strobe[1] |-> $past(p2_tx_msg.valid))
		else $error("port 2 tx strobe without message");
	a_p1rx_strobe_cause: assert property (cap_strobe[2] |-> $past(p1_rx_msg.valid))
		else $error("port 1 rx strobe without message");
	a_p1tx_strobe_cause: assert property (cap_strobe[3] |-> $past(p1_tx_msg.valid))
		else $error("port 1 tx strobe without message");
	a_strobe_sets_flag: assert property (|cap_strobe |-> (cap_strobe & ~irq_pending) == 4'h0)
		else $error("strobe without pending flag");
	a_flag_stays_set: assert property (!$rose(s_axi_bvalid) |->
		(~irq_pending & $past(irq_pending)) == 4'h0)
		else $error("pending flag dropped without a write");
	a_irq_needs_flag: assert property (irq |-> irq_pending != 4'h0)
		else $error("interrupt without pending flag");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_aux_addr_stable: assert property (!$rose(s_axi_bvalid) |-> $stable(aux_addr))
		else $error("auxiliary address changed without a write");
endmodule

bind ptc_port_config ptc_port_config_chk ptc_port_config_chk_i (.aclk, .aresetn,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .p2_rx_msg, .p2_tx_msg, .p1_rx_msg, .p1_tx_msg, .cap_strobe,
	.irq_pending, .aux_addr, .irq);

/* dv/testbench.sv */
// testbench: register, role, address, lock and interrupt checks
`timescale 1ns/1ps
module testbench;
	import ptc_pkg::*;
	logic        aclk, aresetn, irq;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata, s_axi_rdata, r;
	logic [3:0]  s_axi_wstrb, cap_strobe, irq_pending;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	ptc_msg_t    p2_rx_msg, p2_tx_msg, p1_rx_msg, p1_tx_msg;
	logic [47:0] aux_addr, aux_exp;
	logic [47:0] adr [5];
	logic [33:0] bus_q [$];
	logic [3:0]  cap_q [$];
	logic        seen;
	int          failures, tests_run;

	ptc_port_config ptc_port_config_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.p2_rx_msg, .p2_tx_msg, .p1_rx_msg, .p1_tx_msg, .cap_strobe, .irq_pending,
		.aux_addr, .irq);
	ptc_frame_src src_i (.aclk, .p2_rx_msg, .p2_tx_msg, .p1_rx_msg, .p1_tx_msg);

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [47:0] e, input logic [47:0] s);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wrap_up;
		if (failures == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
		logic aw, w, b;
		bus_q.push_back({e, 32'h0});
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			aw = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end while (!b);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
		logic ar, rv;
		bus_q.push_back({e, d});
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			ar = s_axi_arready;
			rv = s_axi_rvalid;
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'b0;
		end while (!rv);
		s_axi_rready <= 1'b0;
	endtask
	task automatic msg(input int p, input logic s, input logic [47:0] a, input logic e);
		cap_q.push_back(4'(e) << p);
		src_i.send(p, s, !s, a, p);
	endtask
	task automatic chk_irq(input logic e);
		@(negedge aclk);
		chk("irq", e, irq);
	endtask
	// ----------------------------------------------------------------
	// monitor
	// ----------------------------------------------------------------
	always @(negedge aclk) begin
		if (s_axi_bvalid && s_axi_bready) chk("bresp", bus_q.pop_front(), {s_axi_bresp, 32'h0});
		if (s_axi_rvalid && s_axi_rready) chk("rdata", bus_q.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (seen) chk("strobe", cap_q.pop_front(), cap_strobe);
		seen = p2_rx_msg.valid | p2_tx_msg.valid | p1_rx_msg.valid | p1_tx_msg.valid;
	end
	initial begin
		repeat (5000) @(posedge aclk);
		failures++;
		wrap_up();
	end
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, seen, failures, tests_run} = '0;
		s_axi_wstrb = 4'hF;
		void'($urandom(32'h640B));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF_CFG, 32'h4300_0000, RESP_OKAY);
		rd(OFF_AUX_UPPER, 32'h0, RESP_OKAY);
		rd(OFF_AUX_LOWER, 32'h0, RESP_OKAY);
		rd(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
		wr(12'h1A0, $urandom, RESP_SLVERR);
		rd(12'h1A0, 32'h0, RESP_SLVERR);
		r = $urandom;
		wr(OFF_CFG, r, RESP_OKAY);
		rd(OFF_CFG, r & 32'hFF80_0000, RESP_OKAY);
		aux_exp = {16'($urandom) & 16'hFEFF, 32'($urandom)};
		wr(OFF_AUX_UPPER, {16'($urandom), aux_exp[47:32]}, RESP_OKAY);
		wr(OFF_AUX_LOWER, aux_exp[31:0], RESP_OKAY);
		rd(OFF_AUX_UPPER, {16'h0, aux_exp[47:32]}, RESP_OKAY);
		chk("aux_addr", aux_exp, aux_addr);
		adr = '{48'h0100_5E00_0181, 48'h0100_5E00_0182, 48'h0100_5E00_0183,
			48'h0100_5E00_0184, aux_exp};
		// roles on both ports, locks off
		for (int m = 0; m < 2; m++) begin
			wr(OFF_CFG, 32'h4000_0000 | (32'(m) << 31) | (32'(m) << 23), RESP_OKAY);
			for (int p = 0; p < 4; p++) begin
				for (int s = 0; s < 2; s++) msg(p, s[0], adr[0], s[0] == (p[0] == m[0]));
			end
		end
		// one address enabled at a time
		for (int i = 0; i < 5; i++) begin
			wr(OFF_CFG, 32'h4000_0000 >> i, RESP_OKAY);
			msg(0, 1'b1, adr[i], 1'b1);
			msg(0, 1'b1, adr[(i + 1) % 5], 1'b0);
		end
		// locks, then the interrupt path
		wr(OFF_CFG, 32'h4300_0000, RESP_OKAY);
		wr(OFF_IRQ_STAT, 32'hF, RESP_OKAY);
		rd(OFF_IRQ_STAT, 32'h0, RESP_OKAY);
		msg(0, 1'b1, adr[0], 1'b1);
		msg(0, 1'b1, adr[0], 1'b0);
		msg(1, 1'b0, adr[0], 1'b1);
		msg(1, 1'b0, adr[0], 1'b0);
		chk_irq(1'b0);
		chk("irq_pending", 48'h3, irq_pending);
		wr(OFF_IRQ_MASK, 32'h3, RESP_OKAY);
		chk_irq(1'b1);
		rd(OFF_IRQ_STAT, 32'h3, RESP_OKAY);
		wr(OFF_IRQ_STAT, 32'h1, RESP_OKAY);
		rd(OFF_IRQ_STAT, 32'h2, RESP_OKAY);
		msg(0, 1'b1, adr[0], 1'b1);
		wr(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
		chk_irq(1'b0);
		chk("irq_pending", 48'h3, irq_pending);
		wr(OFF_IRQ_STAT, 32'hF, RESP_OKAY);
		wr(OFF_IRQ_MASK, 32'hF, RESP_OKAY);
		chk_irq(1'b0);
		chk("irq_pending", 48'h0, irq_pending);
		@(posedge aclk);
		wrap_up();
	end
endmodule
